/* rtl/spio_defines.svh */
// register offsets, reset values and widths for the shared pin port
`ifndef SPIO_DEFINES_SVH
`define SPIO_DEFINES_SVH
`define SPIO_WIDTH          16
`define SPIO_OFS_DIR        12'h000
`define SPIO_OFS_LATCH      12'h004
`define SPIO_OFS_LEVEL      12'h008
`define SPIO_OFS_ODRAIN     12'h00C
`define SPIO_OFS_ANALOG     12'h010
`define SPIO_OFS_SET_LATCH  12'h014
`define SPIO_OFS_CLR_LATCH  12'h018
`define SPIO_OFS_OWNER      12'h01C
`define SPIO_RST_DIR        16'hFFFF
`define SPIO_RST_LATCH      16'h0000
`define SPIO_RST_ODRAIN     16'h0000
`define SPIO_RST_ANALOG     16'hFFFF
`define SPIO_IMPL_MASK      16'hFFFF
`define SPIO_ANALOG_MASK    16'hFFFF
`define SPIO_INONLY_MASK    16'h0000
`endif

/* rtl/spio_pin_mux.sv */
// per-pin output ownership mux, open-drain and input gating
`timescale 1ns/1ps
`default_nettype none
module spio_pin_mux
(
    input  wire logic latch_bit,
    input  wire logic dir_bit,
    input  wire logic odrain_bit,
    input  wire logic analog_bit,
    input  wire logic periph_enable,
    input  wire logic periph_drive,
    input  wire logic periph_out,
    input  wire logic periph_oe,
    input  wire logic pin_in,
    output logic      pin_out,
    output logic      pin_oe,
    output logic      periph_in,
    output logic      level_bit
);
    logic own_periph;
    logic data_sel;
    logic oe_sel;
    always_comb
    begin
        // peripheral owns the pin only while enabled and driving
        own_periph = periph_enable && periph_drive;
        data_sel   = own_periph ? periph_out : latch_bit;
        oe_sel     = own_periph ? periph_oe : !dir_bit;
        // open drain: drive only lows, release instead of high
        pin_out    = odrain_bit ? 1'b0 : data_sel;
        pin_oe     = odrain_bit ? (oe_sel && !data_sel) : oe_sel;
        // analog output keeps driving digital level
        // peripheral sees pin unless the port owns it as an output; open-drain release still reads low
        periph_in  = (oe_sel && !own_periph) ? 1'b0 : pin_in;
        // analog inputs read low
        level_bit  = (analog_bit && dir_bit) ? 1'b0 : pin_in;
    end
endmodule // spio_pin_mux
`default_nettype wire

/* rtl/spio_pkg.sv */
// types for the shared pin port
package spio_pkg;
    typedef enum logic [1:0]
    {
        SPIO_IDLE = 2'b00,
        SPIO_DATA = 2'b01
    } spio_state_t;
    typedef logic [15:0] spio_word_t;
endpackage

/* rtl/spio_port.sv */
// shared pin parallel_io port with AHB-Lite register slave
`timescale 1ns/1ps
`default_nettype none
`include "spio_defines.svh"
module spio_port
    import spio_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic        hsel,
    input  wire logic [11:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic [15:0] periph_enable,
    input  wire logic [15:0] periph_drive,
    input  wire logic [15:0] periph_out,
    input  wire logic [15:0] periph_oe,
    output logic      [15:0] periph_in,
    input  wire logic [15:0] pin_in,
    output logic      [15:0] pin_out,
    output logic      [15:0] pin_oe,
    output logic      [15:0] analog_select
);
    spio_state_t state;
    spio_state_t next_state;
    spio_word_t  dir;
    spio_word_t  next_dir;
    spio_word_t  latch;
    spio_word_t  next_latch;
    spio_word_t  odrain;
    spio_word_t  next_odrain;
    spio_word_t  analog;
    spio_word_t  next_analog;
    spio_word_t  level_sync;
    spio_word_t  level_raw;
    spio_word_t  own_word;
    logic [11:0] addr_q;
    logic [11:0] next_addr_q;
    logic        wr_q;
    logic        next_wr_q;
    logic [31:0] next_hrdata;
    logic        take;
    spio_word_t  wdata;
    spio_word_t  impl;
    spio_word_t  pin_out_raw;
    spio_word_t  pin_oe_raw;
    spio_word_t  periph_in_raw;
    spio_word_t  next_level_sync;
    spio_word_t  gate_en;
    spio_word_t  inonly;
    spio_word_t  analog_eff;
    spio_word_t  rd_word;
    logic [11:0] rd_addr;
    logic        rd_take;
    logic        hit_dir;
    logic        hit_latch;
    logic        hit_level;
    logic        hit_odrain;
    logic        hit_analog;
    logic        hit_set;
    logic        hit_clr;

    assign impl       = `SPIO_IMPL_MASK;
    assign inonly     = `SPIO_INONLY_MASK;
    assign hreadyout  = 1'b1;
    assign hresp      = 1'b0;
    assign take       = hsel && hready && htrans[1];
    assign rd_take    = take && !hwrite;
    assign rd_addr    = {haddr[11:2], 2'b00};
    assign wdata      = hwdata[15:0] & impl;
    // input-only sharers never compete for the output
    assign gate_en    = periph_enable & ~inonly;
    assign own_word   = gate_en & periph_drive;
    assign analog_eff = analog & `SPIO_ANALOG_MASK;

    genvar i;
    generate
        for (i = 0; i < `SPIO_WIDTH; i++)
        begin : g_pin
            spio_pin_mux u_mux
            (
                .latch_bit     (latch[i]),
                .dir_bit       (dir[i]),
                .odrain_bit    (odrain[i]),
                .analog_bit    (analog[i]),
                .periph_enable (gate_en[i]),
                .periph_drive  (periph_drive[i]),
                .periph_out    (periph_out[i]),
                .periph_oe     (periph_oe[i]),
                .pin_in        (pin_in[i]),
                .pin_out       (pin_out_raw[i]),
                .pin_oe        (pin_oe_raw[i]),
                .periph_in     (periph_in_raw[i]),
                .level_bit     (level_raw[i])
            );
        end
    endgenerate

    // unimplemented bits never drive and never reach peripherals
    assign pin_out       = pin_out_raw & impl;
    assign pin_oe        = pin_oe_raw & impl;
    assign periph_in     = periph_in_raw & impl & ~analog_eff;
    assign analog_select = analog_eff;

    // bus phase tracking; the slave never stretches, so every data phase is one cycle
    always_comb
    begin
        next_state  = state;
        next_addr_q = addr_q;
        next_wr_q   = 1'b0;
        case (state)
            SPIO_IDLE, SPIO_DATA:
            begin
                if (take)
                begin
                    next_addr_q = rd_addr;
                    next_wr_q   = hwrite;
                    next_state  = SPIO_DATA;
                end
                else
                begin
                    next_state = SPIO_IDLE;
                end
            end
            default:
            begin
                next_state = SPIO_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state  <= SPIO_IDLE;
            addr_q <= 12'h000;
            wr_q   <= 1'b0;
        end
        else
        begin
            state  <= next_state;
            addr_q <= next_addr_q;
            wr_q   <= next_wr_q;
        end
    end

    // write strobes in the data phase, when hwdata stands
    always_comb
    begin
        hit_dir    = 1'b0;
        hit_latch  = 1'b0;
        hit_level  = 1'b0;
        hit_odrain = 1'b0;
        hit_analog = 1'b0;
        hit_set    = 1'b0;
        hit_clr    = 1'b0;
        if (wr_q)
        begin
            case (addr_q)
                `SPIO_OFS_DIR:       hit_dir    = 1'b1;
                `SPIO_OFS_LATCH:     hit_latch  = 1'b1;
                `SPIO_OFS_LEVEL:     hit_level  = 1'b1;
                `SPIO_OFS_ODRAIN:    hit_odrain = 1'b1;
                `SPIO_OFS_ANALOG:    hit_analog = 1'b1;
                `SPIO_OFS_SET_LATCH: hit_set    = 1'b1;
                `SPIO_OFS_CLR_LATCH: hit_clr    = 1'b1;
                // owner status is read-only; it and unmapped offsets ignore writes
                default:             hit_dir    = 1'b0;
            endcase
        end
    end

    always_comb
    begin
        next_dir    = dir;
        next_latch  = latch;
        next_odrain = odrain;
        next_analog = analog;
        if (hit_dir)
        begin
            next_dir = wdata;
        end
        if (hit_latch || hit_level)
        begin
            // a pin level write lands in the latch, never on the pins
            next_latch = wdata;
        end
        // set and clear touch only the bits written as ones
        if (hit_set)
        begin
            next_latch = latch | wdata;
        end
        if (hit_clr)
        begin
            next_latch = latch & ~wdata;
        end
        if (hit_odrain)
        begin
            next_odrain = wdata;
        end
        if (hit_analog)
        begin
            next_analog = wdata & `SPIO_ANALOG_MASK;
        end
    end

    // reset leaves every pin not owned by a peripheral an input, and selects analog on all
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            dir    <= `SPIO_RST_DIR;
            latch  <= `SPIO_RST_LATCH;
            odrain <= `SPIO_RST_ODRAIN;
            analog <= `SPIO_RST_ANALOG;
        end
        else
        begin
            dir    <= next_dir;
            latch  <= next_latch;
            odrain <= next_odrain;
            analog <= next_analog;
        end
    end

    // eight registers: dir, latch, level, odrain, analog, set, clear, owner
    // read word picked in the address phase, registered for the data phase
    always_comb
    begin
        rd_word     = 16'h0000;
        next_hrdata = hrdata;
        case (rd_addr)
            `SPIO_OFS_DIR:    rd_word = dir;
            `SPIO_OFS_LATCH:  rd_word = latch;
            `SPIO_OFS_LEVEL:  rd_word = level_sync;
            `SPIO_OFS_ODRAIN: rd_word = odrain;
            `SPIO_OFS_ANALOG: rd_word = analog;
            `SPIO_OFS_OWNER:  rd_word = own_word;
            default:          rd_word = 16'h0000;
        endcase
        // unimplemented bits read zero whatever the register holds
        if (rd_take)
        begin
            next_hrdata = {16'h0000, rd_word & impl};
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            hrdata <= 32'h00000000;
        end
        else
        begin
            hrdata <= next_hrdata;
        end
    end

    // one sampling stage on the pins; software waits a cycle after writes
    always_comb
    begin
        next_level_sync = level_raw;
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            level_sync <= 16'h0000;
        end
        else
        begin
            level_sync <= next_level_sync;
        end
    end
endmodule // spio_port
`default_nettype wire

/* tb/spio_pad_model.sv */
// pad model: port driver, external source and pull-up on each pin
`timescale 1ns/1ps
`default_nettype none
module spio_pad_model
(
    input  wire logic [15:0] pin_out,
    input  wire logic [15:0] pin_oe,
    input  wire logic [15:0] ext_en,
    input  wire logic [15:0] ext_val,
    output logic      [15:0] pin_in
);
    // released pins take the external source when enabled, else the pull-up, never hold the last value
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & (~ext_en | ext_val));
endmodule // spio_pad_model
`default_nettype wire

/* tb/spio_port_asserts.sv */
// port-level properties of the shared pin port
`timescale 1ns/1ps
`default_nettype none
`include "spio_defines.svh"
module spio_chk
(
    input wire logic        clk,
    input wire logic        reset_n,
    input wire logic        hsel,
    input wire logic [11:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic [15:0] periph_enable,
    input wire logic [15:0] periph_drive,
    input wire logic [15:0] periph_out,
    input wire logic [15:0] periph_oe,
    input wire logic [15:0] periph_in,
    input wire logic [15:0] pin_out,
    input wire logic [15:0] pin_oe,
    input wire logic [15:0] analog_select
);
    logic [15:0] owned;
    logic        go;
    assign owned = periph_enable & periph_drive;
    assign go = hsel & hready & htrans[1];
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    bus_answer_a: assert property (hreadyout && !hresp)
        else $error("bus answer not ready or not okay");
    owner_oe_a: assert property ((owned & ~periph_oe & pin_oe) == 16'h0000)
        else $error("port drives a peripheral-owned pin");
    owner_data_a: assert property ((owned & pin_oe & (pin_out ^ periph_out)) == 16'h0000)
        else $error("owned pin data not from peripheral");
    no_loop_a: assert property ((periph_in & pin_oe & ~owned) == 16'h0000)
        else $error("port output loops into peripheral");
    analog_in_a: assert property ((periph_in & analog_select) == 16'h0000)
        else $error("analog pin seen as digital input");
    analog_rst_a: assert property ($rose(reset_n) |-> analog_select == 16'hFFFF)
        else $error("analog select not all ones after reset");
    dir_rst_a: assert property ($rose(reset_n) |-> (pin_oe & ~owned) == 16'h0000)
        else $error("port pin driven after reset");
    analog_wr_a: assert property (go && hwrite && haddr == `SPIO_OFS_ANALOG ##1 1'b1
        |=> analog_select == $past(hwdata[15:0])) else $error("analog select write lost");
    unmapped_rd_a: assert property (go && !hwrite && haddr >= 12'h020 |=> hrdata == 32'h0)
        else $error("unmapped read not zero");
endmodule // spio_chk
`default_nettype wire

/* tb/spio_port_tb.sv */
// self-checking bench for the shared pin port
`timescale 1ns/1ps
`default_nettype none
`include "spio_defines.svh"
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin err_count++; \
    $display("unexpected %s exp %h got %h", n, e, g); end end
module spio_port_tb
    import spio_pkg::*;
;
    logic clk, reset_n, hsel, hwrite, hready, hreadyout, hresp;
    logic [11:0] haddr;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] hwdata, hrdata, d;
    spio_word_t  periph_enable, periph_drive, periph_out, periph_oe, periph_in;
    spio_word_t  pin_in, pin_out, pin_oe, analog_select, ext_en, ext_val, r, l;
    int          err_count, compares;
    assign hready = hreadyout;
    spio_port i_dut (.clk, .reset_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready, .hrdata, .hreadyout, .hresp, .periph_enable, .periph_drive, .periph_out,
        .periph_oe, .periph_in, .pin_in, .pin_out, .pin_oe, .analog_select);
    spio_pad_model i_pad (.pin_out, .pin_oe, .ext_en, .ext_val, .pin_in);
    function automatic spio_word_t xoe();
        return (periph_enable & periph_drive & periph_oe) | (~(periph_enable & periph_drive) & ~r);
    endfunction
    function automatic spio_word_t xout();
        return (periph_enable & periph_drive & periph_out) | (~(periph_enable & periph_drive) & l);
    endfunction
    task automatic hold();
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
    endtask
    task automatic ph(input logic [11:0] a, input logic w);
        haddr <= a;
        hwrite <= w;
        htrans <= 2'b10;
        hold();
        htrans <= 2'b00;
    endtask
    task automatic wr(input logic [11:0] a, input spio_word_t v);
        ph(a, 1'b1);
        hwdata <= {16'h0000, v};
        hold();
        @(posedge clk);
    endtask
    task automatic chr(input logic [11:0] a, input spio_word_t x, input string n);
        ph(a, 1'b0);
        hold();
        d = hrdata;
        `CHK(n, {16'h0000, x}, d)
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial
    begin
        repeat (5000) @(posedge clk);
        err_count++;
        summarize();
    end
    initial
    begin
        reset_n = 1'b0;
        hsel = 1'b1;
        hsize = 3'b010;
        {haddr, htrans, hwrite, hwdata, r, l} = '0;
        {periph_enable, periph_drive, periph_out, periph_oe, ext_en, ext_val} = '0;
        void'($urandom(19702));
        repeat (5) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        chr(`SPIO_OFS_DIR, 16'hFFFF, "dir");
        chr(`SPIO_OFS_LATCH, 16'h0000, "latch");
        chr(`SPIO_OFS_ODRAIN, 16'h0000, "odrain");
        chr(`SPIO_OFS_ANALOG, 16'hFFFF, "analog");
        chr(12'h020, 16'h0000, "unmapped");
        $display("test reset done");
        wr(`SPIO_OFS_ANALOG, 16'h0000);
        for (int i = 0; i < 6; i++)
        begin
            r = (i == 0) ? 16'h00FF : 16'($urandom);
            l = 16'($urandom);
            periph_enable <= (i == 0) ? 16'h0000 : 16'($urandom);
            periph_drive <= 16'($urandom);
            periph_out <= 16'($urandom);
            periph_oe <= 16'($urandom);
            ext_en <= r;
            ext_val <= 16'($urandom);
            wr(`SPIO_OFS_DIR, r);
            wr(`SPIO_OFS_LATCH, l);
            `CHK("pin oe", xoe(), pin_oe)
            `CHK("pin out", xout() & xoe(), pin_out & xoe())
            `CHK("periph in", (periph_enable & periph_drive | r) & pin_in, periph_in)
            chr(`SPIO_OFS_OWNER, periph_enable & periph_drive, "owner");
            chr(`SPIO_OFS_LATCH, l, "latch");
            chr(`SPIO_OFS_LEVEL, (xoe() & xout()) | (~xoe() & (~ext_en | ext_val)), "level");
            wr(`SPIO_OFS_LEVEL, ~l);
            chr(`SPIO_OFS_LATCH, ~l, "level write");
        end
        $display("test ownership done");
        periph_enable <= 16'h0000;
        ext_en <= 16'h0000;
        wr(`SPIO_OFS_ANALOG, 16'hFFFF);
        wr(`SPIO_OFS_DIR, 16'hFFFF);
        chr(`SPIO_OFS_LEVEL, 16'h0000, "analog level");
        wr(`SPIO_OFS_DIR, 16'h0000);
        `CHK("analog oe", 16'hFFFF, pin_oe)
        wr(`SPIO_OFS_ANALOG, 16'h0000);
        wr(`SPIO_OFS_ODRAIN, 16'hFFFF);
        l = 16'($urandom);
        wr(`SPIO_OFS_LATCH, l);
        `CHK("drain high", 16'h0000, pin_oe & pin_out)
        chr(`SPIO_OFS_LEVEL, l, "drain level");
        wr(`SPIO_OFS_SET_LATCH, 16'h00F0);
        chr(`SPIO_OFS_LATCH, l | 16'h00F0, "latch set");
        wr(`SPIO_OFS_CLR_LATCH, 16'h0F0F);
        chr(`SPIO_OFS_LATCH, (l | 16'h00F0) & ~16'h0F0F, "latch clear");
        $display("test analog and drain done");
        reset_n <= 1'b0;
        @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        chr(`SPIO_OFS_DIR, 16'hFFFF, "dir again");
        chr(`SPIO_OFS_ODRAIN, 16'h0000, "odrain again");
        $display("test second reset done");
        summarize();
    end
endmodule // spio_port_tb
bind spio_port spio_chk i_chk (.clk, .reset_n, .hsel, .haddr, .htrans, .hwrite, .hwdata,
    .hready, .hrdata, .hreadyout, .hresp, .periph_enable, .periph_drive, .periph_out,
    .periph_oe, .periph_in, .pin_out, .pin_oe, .analog_select);
`default_nettype wire
